// File: verilog/thbs_pkg.sv
package thbs_pkg;

    // ======================================================================
    // Register map
    localparam logic [3:0] OFF_SELCNT    = 4'h0;
    localparam logic [3:0] OFF_CTRL      = 4'h1;
    localparam logic [3:0] OFF_IRQ_STAT  = 4'h2;
    localparam logic [3:0] OFF_IRQ_MASK  = 4'h3;
    localparam logic [3:0] OFF_STATUS    = 4'h4;

    localparam int         SEL_BIT       = 7;
    localparam int         CTRL_MODE_BIT = 0;
    localparam int         CTRL_FCS_BIT  = 1;
    localparam int         IRQ_EOT_BIT   = 0;

    localparam logic [7:0] SELCNT_RST    = 8'h00;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] CTRL_MASK     = 8'h03;
    localparam logic [7:0] IRQ_RST       = 8'h00;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h01;
    localparam logic [7:0] RD_IDLE       = 8'h00;

    // ======================================================================
    // Message geometry
    localparam logic       MODE_BOS       = 1'b0;
    localparam logic       MODE_MOS       = 1'b1;
    localparam logic [6:0] CNT_ZERO       = 7'h00;
    localparam logic [6:0] CNT_ONE        = 7'h01;
    localparam logic [6:0] BOS_MSG_OCTETS = 7'h02;
    localparam logic [6:0] FCS_OCTETS     = 7'h02;
    localparam logic [15:0] BUF0_BASE     = 16'h0600;
    localparam logic [15:0] BUF1_BASE     = 16'h0700;

    // ======================================================================
    // Types
    typedef struct packed {
        logic       mode;
        logic       fcs_en;
        logic [6:0] count;
    } thbs_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        buf_sel;
        logic [15:0] addr;
        logic        fcs;
    } thbs_fetch_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DATA  = 2'b01,
        ST_CHECK = 2'b10
    } thbs_state_t;

    function automatic logic [6:0] thbs_inc(input logic [6:0] x);
        thbs_inc = 7'(x + CNT_ONE);
    endfunction

endpackage

// File: verilog/thbs_sender.sv
`timescale 1ns/1ns
module thbs_sender (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Launch
    input  wire logic                start,
    input  wire logic                start_buf,
    input  wire thbs_pkg::thbs_cfg_t cfg,
    // Link side
    input  wire logic                link_ready,
    output thbs_pkg::thbs_fetch_t    fetch,
    // Events
    output logic                     freed,
    output logic                     freed_buf,
    output logic                     eot,
    output logic                     active
);
    import thbs_pkg::*;

    // ======================================================================
    // State
    thbs_state_t state_q, state_d;
    thbs_cfg_t   cfg_q;
    logic        buf_q;
    logic [6:0]  octet_q, octet_d;
    logic [6:0]  rep_q, rep_d;
    logic [6:0]  chk_q, chk_d;
    logic        freed_d, eot_d;

    wire        take_start = (state_q == ST_IDLE) && start;
    wire        cur_buf    = take_start ? start_buf : buf_q;
    wire        empty_mos  = (cfg.mode == MODE_MOS) && (cfg.count == CNT_ZERO);
    wire [6:0]  msg_len    = (cfg_q.mode == MODE_MOS) ? cfg_q.count : BOS_MSG_OCTETS;
    wire        last_oct   = (octet_q == 7'(msg_len - CNT_ONE));
    wire [6:0]  rep_next   = thbs_inc(rep_q);
    wire        rep_done   = (cfg_q.count != CNT_ZERO) && (rep_next == cfg_q.count);
    wire        last_chk   = (chk_q == 7'(FCS_OCTETS - CNT_ONE));
    wire [15:0] base       = cur_buf ? BUF1_BASE : BUF0_BASE;

    always_comb begin
        state_d = state_q;
        octet_d = octet_q;
        rep_d   = rep_q;
        chk_d   = chk_q;
        freed_d = 1'b0;
        eot_d   = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // An empty message frees its buffer at once; nothing to send
                if (start && empty_mos) begin
                    freed_d = 1'b1;
                    eot_d   = 1'b1;
                end else if (start) begin
                    state_d = ST_DATA;
                    octet_d = CNT_ZERO;
                    rep_d   = CNT_ZERO;
                end
            end
            ST_DATA: begin
                if (link_ready && !last_oct) begin
                    octet_d = thbs_inc(octet_q);
                end else if (link_ready && cfg_q.mode == MODE_MOS) begin
                    octet_d = CNT_ZERO;
                    freed_d = 1'b1;
                    if (cfg_q.fcs_en) begin
                        state_d = ST_CHECK;
                        chk_d   = CNT_ZERO;
                    end else begin
                        state_d = ST_IDLE;
                        eot_d   = 1'b1;
                    end
                end else if (link_ready) begin
                    octet_d = CNT_ZERO;
                    rep_d   = rep_next;
                    if (rep_done) begin
                        state_d = ST_IDLE;
                        freed_d = 1'b1;
                        eot_d   = 1'b1;
                    end
                end
            end
            ST_CHECK: begin
                if (link_ready && last_chk) begin
                    state_d = ST_IDLE;
                    eot_d   = 1'b1;
                end else if (link_ready) begin
                    chk_d = thbs_inc(chk_q);
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ST_IDLE;
            cfg_q     <= '0;
            buf_q     <= 1'b0;
            octet_q   <= CNT_ZERO;
            rep_q     <= CNT_ZERO;
            chk_q     <= CNT_ZERO;
            fetch     <= '0;
            freed     <= 1'b0;
            freed_buf <= 1'b0;
            eot       <= 1'b0;
            active    <= 1'b0;
        end else begin
            state_q       <= state_d;
            octet_q       <= octet_d;
            rep_q         <= rep_d;
            chk_q         <= chk_d;
            freed         <= freed_d;
            eot           <= eot_d;
            freed_buf     <= cur_buf;
            buf_q         <= cur_buf;
            active        <= (state_d != ST_IDLE);
            fetch.valid   <= (state_d != ST_IDLE);
            fetch.buf_sel <= cur_buf;
            fetch.addr    <= 16'(base + {9'h000, octet_d});
            fetch.fcs     <= (state_d == ST_CHECK);
            // Settings are frozen per message so a mid-message write cannot corrupt it
            if (take_start) begin
                cfg_q <= cfg;
            end
        end
    end

    // ======================================================================
    // Checks
    chk_bos_endless: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == ST_DATA && cfg_q.mode == MODE_BOS && cfg_q.count == CNT_ZERO)
        |=> !eot && state_q == ST_DATA)
        else $error("endless repeat stopped");
    chk_bos_addr: assert property (@(posedge clk) disable iff (!reset_n)
        (fetch.valid && cfg_q.mode == MODE_BOS)
        |-> fetch.addr[6:0] < BOS_MSG_OCTETS)
        else $error("bit-oriented fetch beyond message");
    chk_mos_last: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == ST_DATA && cfg_q.mode == MODE_MOS && link_ready && last_oct)
        |=> freed && (fetch.fcs == cfg_q.fcs_en))
        else $error("message length end mishandled");
    chk_fcs_pair: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == ST_CHECK && $past(state_q) == ST_DATA)
        |-> fetch.fcs && !eot && cfg_q.fcs_en && (cfg_q.mode == MODE_MOS))
        else $error("checksum phase entered wrongly");

endmodule

// File: verilog/thbs_top.sv
`timescale 1ns/1ns
module thbs_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    // Link side
    input  wire logic                   link_ready,
    output thbs_pkg::thbs_fetch_t       fetch,
    // Interrupt
    output logic                        tx_end_of_transfer_irq
);
    import thbs_pkg::*;

    // ======================================================================
    // Registers
    logic [7:0] selcnt_q;
    logic [7:0] ctrl_q;
    logic [7:0] stat_q;
    logic [7:0] mask_q;
    logic [1:0] busy_q;
    logic       pend_q;
    logic       pend_buf_q;

    wire        active;
    wire        freed;
    wire        freed_buf;
    wire        eot;

    // ======================================================================
    // Decode
    wire        wr_selcnt = reg_wr && (reg_addr == OFF_SELCNT);
    wire        wr_ctrl   = reg_wr && (reg_addr == OFF_CTRL);
    wire        wr_stat   = reg_wr && (reg_addr == OFF_IRQ_STAT);
    wire        wr_mask   = reg_wr && (reg_addr == OFF_IRQ_MASK);
    wire        wsel      = reg_wdata[SEL_BIT];
    // A select naming a buffer still in flight is dropped, not queued
    wire        sel_ok    = !busy_q[wsel];
    wire        launch    = pend_q && !active;
    wire [1:0]  set_busy  = (wr_selcnt && sel_ok) ? (wsel ? 2'b10 : 2'b01) : 2'b00;
    wire [1:0]  clr_busy  = freed ? (freed_buf ? 2'b10 : 2'b01) : 2'b00;
    wire [1:0]  busy_d    = set_busy | (busy_q & ~clr_busy);
    wire        avail     = busy_q[0] && !busy_q[1];
    wire [7:0]  eot_set   = eot ? (8'h01 << IRQ_EOT_BIT) : 8'h00;
    wire [7:0]  stat_clr  = wr_stat ? reg_wdata : 8'h00;
    // Set beats clear so an event in the clearing cycle is kept
    wire [7:0]  stat_d    = (eot_set | (stat_q & ~stat_clr)) & IRQ_MASK_BITS;
    wire        irq_d     = |(stat_q & mask_q);
    wire [7:0]  rd_val    = (reg_addr == OFF_SELCNT)   ? {avail, selcnt_q[6:0]} :
                            (reg_addr == OFF_CTRL)     ? (ctrl_q & CTRL_MASK) :
                            (reg_addr == OFF_IRQ_STAT) ? stat_q :
                            (reg_addr == OFF_IRQ_MASK) ? mask_q :
                            (reg_addr == OFF_STATUS)   ? {5'h00, active, busy_q} :
                            RD_IDLE;
    wire thbs_cfg_t cfg   = '{mode:   ctrl_q[CTRL_MODE_BIT],
                              fcs_en: ctrl_q[CTRL_FCS_BIT],
                              count:  selcnt_q[6:0]};
    // An empty message-oriented launch frees its buffer without ever sending
    wire        empty_launch = (cfg.mode == MODE_MOS) && (cfg.count == CNT_ZERO);

    // ======================================================================
    // Sequencer
    thbs_sender u_sender (
        .clk        (clk),
        .reset_n    (reset_n),
        .start      (launch),
        .start_buf  (pend_buf_q),
        .cfg        (cfg),
        .link_ready (link_ready),
        .fetch      (fetch),
        .freed      (freed),
        .freed_buf  (freed_buf),
        .eot        (eot),
        .active     (active)
    );

    // ======================================================================
    // Flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            selcnt_q               <= SELCNT_RST;
            ctrl_q                 <= CTRL_RST;
            stat_q                 <= IRQ_RST;
            mask_q                 <= IRQ_RST;
            busy_q                 <= 2'h0;
            pend_q                 <= 1'b0;
            pend_buf_q             <= 1'b0;
            reg_rdata              <= RD_IDLE;
            tx_end_of_transfer_irq <= 1'b0;
        end else begin
            busy_q                 <= busy_d;
            stat_q                 <= stat_d;
            tx_end_of_transfer_irq <= irq_d;
            reg_rdata              <= reg_rd ? rd_val : RD_IDLE;
            if (wr_selcnt) begin
                selcnt_q <= reg_wdata;
            end
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata & CTRL_MASK;
            end
            if (wr_mask) begin
                mask_q <= reg_wdata & IRQ_MASK_BITS;
            end
            if (wr_selcnt && sel_ok) begin
                pend_q     <= 1'b1;
                pend_buf_q <= wsel;
            end else if (launch) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Checks
    chk_sel_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_selcnt && sel_ok && !reg_wdata[SEL_BIT]) |=> busy_q[0] && pend_q && !pend_buf_q)
        else $error("select zero not taken");
    chk_launch_buf: assert property (@(posedge clk) disable iff (!reset_n)
        (launch && !empty_launch) |=> fetch.valid && (fetch.buf_sel == $past(pend_buf_q)))
        else $error("wrong buffer sent");
    chk_avail_read: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr == OFF_SELCNT) |=> reg_rdata[SEL_BIT] == $past(avail))
        else $error("select readback wrong");
    chk_avail_other: assert property (@(posedge clk) disable iff (!reset_n)
        (busy_q == 2'b01 || busy_q == 2'b10) |-> (avail == busy_q[0]))
        else $error("busy buffer reported free");
    chk_busy_guard: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_selcnt && !sel_ok && !pend_q) |=> !pend_q)
        else $error("busy buffer selected");
    chk_eot_irq: assert property (@(posedge clk) disable iff (!reset_n)
        (eot && mask_q[IRQ_EOT_BIT]) |=> stat_q[IRQ_EOT_BIT] ##1 tx_end_of_transfer_irq)
        else $error("end of transfer not signalled");
    chk_free_last: assert property (@(posedge clk) disable iff (!reset_n)
        (freed && set_busy == 2'b00) |=> !busy_q[$past(freed_buf)])
        else $error("buffer not freed");

endmodule

// File: verif/thbs_link_model.sv
`timescale 1ns/1ns
module thbs_link_model (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Bench control
    input  wire logic                  slow,
    input  wire logic                  clear,
    // Link
    input  wire thbs_pkg::thbs_fetch_t fetch,
    output logic                       link_ready,
    // Observations
    output logic [15:0]                n_data,
    output logic [15:0]                n_fcs,
    output logic [15:0]                last_addr
);
    import thbs_pkg::*;

    logic tog_q;

    // ======================================================================
    // Slot taker
    // Slow mode takes every other slot, so the sender has to hold its offer
    assign link_ready = !slow || tog_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_q     <= 1'b0;
            n_data    <= 16'h0000;
            n_fcs     <= 16'h0000;
            last_addr <= 16'h0000;
        end else begin
            tog_q <= !tog_q;
            if (clear) begin
                n_data    <= 16'h0000;
                n_fcs     <= 16'h0000;
                last_addr <= 16'h0000;
            end else if (fetch.valid && link_ready) begin
                if (fetch.fcs) begin
                    n_fcs <= n_fcs + 16'h0001;
                end else begin
                    n_data    <= n_data + 16'h0001;
                    last_addr <= fetch.addr;
                end
            end
        end
    end
endmodule

// File: verif/thbs_top_test.sv
`timescale 1ns/1ns
module thbs_top_test;
    import thbs_pkg::*;

    logic        clk;
    logic        reset_n;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        link_ready;
    thbs_fetch_t fetch;
    logic        irq;
    logic        slow;
    logic        clear;
    logic [15:0] n_data;
    logic [15:0] n_fcs;
    logic [15:0] last_addr;
    logic [7:0]  v;
    int          n_fail;
    int          total_checks;

    // ======================================================================
    // Design and link partner
    thbs_top i_dut (
        .clk                    (clk),
        .reset_n                (reset_n),
        .reg_addr               (reg_addr),
        .reg_wdata              (reg_wdata),
        .reg_wr                 (reg_wr),
        .reg_rd                 (reg_rd),
        .reg_rdata              (reg_rdata),
        .link_ready             (link_ready),
        .fetch                  (fetch),
        .tx_end_of_transfer_irq (irq)
    );

    thbs_link_model i_link (
        .clk        (clk),
        .reset_n    (reset_n),
        .slow       (slow),
        .clear      (clear),
        .fetch      (fetch),
        .link_ready (link_ready),
        .n_data     (n_data),
        .n_fcs      (n_fcs),
        .last_addr  (last_addr)
    );

    always #50 clk = !clk;

    // ======================================================================
    // Bench tasks
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // A gap cycle between strobes keeps each strobe a single assignment per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        // Read data stand only until the next edge, so take them mid-cycle
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic go(input logic [7:0] ctrl, input logic [7:0] sel);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        wr(OFF_CTRL, ctrl);
        wr(OFF_SELCNT, sel);
    endtask

    task automatic wait_idle();
        logic [7:0] s;
        int         i;
        for (i = 0; i < 100; i++) begin
            rd(OFF_STATUS, s);
            if (s[2:0] === 3'b000) begin
                return;
            end
        end
        chk("idle wait", 16'h0000, 16'h0001);
    endtask

    task automatic expect_msg(input logic [15:0] nd, input logic [15:0] nf,
                              input logic [15:0] la);
        wait_idle();
        chk("data slots", n_data, nd);
        chk("fcs slots", n_fcs, nf);
        chk("last addr", last_addr, la);
        rd(OFF_IRQ_STAT, v);
        chk("eot status", v, 16'h0001);
        wr(OFF_IRQ_STAT, 8'h01);
    endtask

    // ======================================================================
    // Watchdog
    initial begin
        #(100 * 20000);
        n_fail++;
        test_done();
    end

    // ======================================================================
    // Tests
    initial begin
        clk       = 1'b0;
        reset_n   = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        slow      = 1'b0;
        clear     = 1'b0;
        n_fail    = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rd(4'(a), v);
            chk("reset value", v, 16'h0000);
        end
        wr(OFF_IRQ_MASK, 8'h01);
        // Message mode with checksum, buffer zero, stalling link
        slow <= 1'b1;
        go(8'h03, 8'h03);
        rd(OFF_SELCNT, v);
        chk("next free busy", v[7], 16'h0001);
        wr(OFF_SELCNT, 8'h05);
        expect_msg(16'h0003, 16'h0002, 16'h0602);
        rd(OFF_SELCNT, v);
        chk("next free idle", v[7], 16'h0000);
        // Interrupt masking and clearing
        go(8'h01, 8'h81);
        wait_idle();
        chk("irq raised", irq, 16'h0001);
        wr(OFF_IRQ_MASK, 8'h00);
        // Mask lands one edge after the strobe, the interrupt flop one edge later
        repeat (2) @(negedge clk);
        chk("irq masked", irq, 16'h0000);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_IRQ_STAT, 8'h01);
        repeat (2) @(negedge clk);
        chk("irq cleared", irq, 16'h0000);
        // Message mode, no checksum, buffer one, fast link
        slow <= 1'b0;
        go(8'h01, 8'h82);
        expect_msg(16'h0002, 16'h0000, 16'h0701);
        // Bit mode ignores checksum enable; three repeats of two octets
        go(8'h02, 8'h03);
        expect_msg(16'h0006, 16'h0000, 16'h0601);
        // Empty message-oriented message sends nothing but still ends
        go(8'h01, 8'h00);
        expect_msg(16'h0000, 16'h0000, 16'h0000);
        // Bit mode with zero count never stops
        go(8'h00, 8'h80);
        repeat (300) @(posedge clk);
        rd(OFF_STATUS, v);
        chk("endless active", v[2], 16'h0001);
        rd(OFF_IRQ_STAT, v);
        chk("endless no eot", v, 16'h0000);
        chk("endless addr", last_addr[15:8], 16'h0007);
        chk("endless buffer", fetch.buf_sel, 16'h0001);
        rd(OFF_SELCNT, v);
        chk("next free other", v[7], 16'h0000);
        // Reset in mid-run stops the endless message
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(OFF_STATUS, v);
        chk("status after reset", v, 16'h0000);
        chk("fetch after reset", fetch.valid, 16'h0000);
        test_done();
    end
endmodule
